/* File: rtl/prfc_flr_fn.sv */
`timescale 1ns/1ns
module prfc_flr_fn (
  input logic clock,
  input logic rst,
  input logic ce,
  input logic trigger,
  input logic done_in,
  input logic [prfc_pkg::ERR_W-1:0] err_set,
  input logic [prfc_pkg::ERR_W-1:0] err_clr,
  output logic active,
  output logic [prfc_pkg::ERR_W-1:0] err_q
);

  logic active_reg;
  logic [prfc_pkg::ERR_W-1:0] err_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else if (ce) begin
      if (trigger) begin
        active_reg <= 1'b1;
      end else if (done_in) begin
        active_reg <= 1'b0;
      end
    end
  end

  // error flags: new events win over a clear, reset returns them to default
  always_ff @(posedge clock) begin
    if (rst) begin
      err_reg <= '0;
    end else if (ce) begin
      if (trigger) begin
        err_reg <= err_set;
      end else begin
        err_reg <= (err_reg & ~err_clr) | err_set;
      end
    end
  end

  assign active = active_reg;
  assign err_q = err_reg;

  a_flr_launch: assert property (@(posedge clock) disable iff (rst)
    ce && trigger |=> active && ((err_q & ~$past(err_set)) == '0))
    else $error("function reset did not start");

  a_flr_release: assert property (@(posedge clock) disable iff (rst)
    ce && active && done_in && !trigger |=> !active)
    else $error("function not re-enabled after done");

  a_flr_hold: assert property (@(posedge clock) disable iff (rst)
    (!ce || (!trigger && !done_in)) |=> active == $past(active))
    else $error("reset-active changed without cause");

endmodule

/* File: rtl/prfc_pkg.sv */
package prfc_pkg;

  localparam int CLK_HZ = 20_000_000;
  localparam int RX_STABLE_MS = 3;
  localparam int RX_STABLE_CYC = (RX_STABLE_MS * CLK_HZ + 999) / 1000;
  localparam int TX_STABLE_CYC = 127;
  localparam int CNT_W = 16;

  localparam int NUM_VF = 4;
  localparam int VF_IDX_W = 2;
  localparam int ADDR_W = 12;
  localparam int VF_SEL_LSB = 8;
  localparam int VF_SEL_W = 4;

  localparam logic [7:0] CAP_LIST_OFS = 8'h80;
  localparam logic [7:0] DEV_CTL_OFS = 8'h88;

  localparam logic [7:0] CAP_ID_VAL = 8'h10;
  localparam logic [7:0] NEXT_PTR_VAL = 8'h00;
  localparam int CAP_ID_LSB = 0;
  localparam int NEXT_PTR_LSB = 8;
  localparam int VER_LSB = 16;
  localparam int VER_W = 3;
  localparam logic [2:0] VER_RST = 3'h0;

  localparam int FLR_BIT = 15;
  localparam int ERR_LSB = 16;
  localparam int ERR_W = 4;
  localparam int PEND_BIT = 21;

  localparam logic [2:0] RXSTAT_DETECTED = 3'h3;

  typedef struct packed {
    logic rx_pll_locked;
    logic phy_status;
    logic [2:0] rx_status;
    logic signal_detect;
    logic tx_pll_locked;
  } prfc_phy_t;

  typedef enum logic [2:0] {
    PRFC_DETECT_QUIET = 3'h1,
    PRFC_DETECT_ACTIVE = 3'h2,
    PRFC_POLLING_ACTIVE = 3'h4
  } prfc_ltssm_t;

endpackage

/* File: rtl/prfc_reset_flr_ctrl.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module prfc_reset_flr_ctrl #(
  parameter int RX_STABLE_CYC = prfc_pkg::RX_STABLE_CYC
) (
  input logic clock,
  input logic rst,
  input logic ce,
  input logic perst_n,
  input logic por_n,
  input prfc_pkg::prfc_phy_t phy,
  input logic pf_flr_capable,
  output logic core_reset_status,
  output logic serdes_por_n,
  output logic rx_digital_reset,
  output logic tx_digital_reset,
  output prfc_pkg::prfc_ltssm_t link_state,
  input logic [prfc_pkg::ADDR_W-1:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [prfc_pkg::NUM_VF-1:0] flr_active,
  input logic [prfc_pkg::NUM_VF-1:0] flr_done,
  input logic [prfc_pkg::NUM_VF-1:0] vf_np_pending,
  input logic [prfc_pkg::NUM_VF-1:0][prfc_pkg::ERR_W-1:0] vf_err_event
);

  // synchroniser for the physical-side levels

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic rx_pll_s;
  logic sig_det_s;
  logic tx_pll_s;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else if (ce) begin
      meta_reg <= {phy.rx_pll_locked, phy.signal_detect, phy.tx_pll_locked};
      sync_reg <= meta_reg;
    end
  end

  assign rx_pll_s = sync_reg[2];
  assign sig_det_s = sync_reg[1];
  assign tx_pll_s = sync_reg[0];

  // core reset status and transceiver power-on reset

  logic core_rst_reg;
  logic serdes_por_n_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      core_rst_reg <= 1'b1;
    end else if (ce) begin
      core_rst_reg <= !(perst_n || por_n);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      serdes_por_n_reg <= 1'b0;
    end else if (ce) begin
      serdes_por_n_reg <= por_n;
    end
  end

  assign core_reset_status = core_rst_reg;
  assign serdes_por_n = serdes_por_n_reg;

  // link training entry

  prfc_pkg::prfc_ltssm_t state_reg;
  prfc_pkg::prfc_ltssm_t state_next;
  logic rx_detected;

  assign rx_detected = phy.phy_status && (phy.rx_status == prfc_pkg::RXSTAT_DETECTED);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      prfc_pkg::PRFC_DETECT_QUIET: begin
        if (rx_pll_s) begin
          state_next = prfc_pkg::PRFC_DETECT_ACTIVE;
        end
      end
      prfc_pkg::PRFC_DETECT_ACTIVE: begin
        if (!rx_pll_s) begin
          state_next = prfc_pkg::PRFC_DETECT_QUIET;
        end else if (rx_detected) begin
          state_next = prfc_pkg::PRFC_POLLING_ACTIVE;
        end
      end
      prfc_pkg::PRFC_POLLING_ACTIVE: begin
        if (!rx_pll_s) begin
          state_next = prfc_pkg::PRFC_DETECT_QUIET;
        end
      end
      default: begin
        state_next = prfc_pkg::PRFC_DETECT_QUIET;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst || core_rst_reg) begin
      state_reg <= prfc_pkg::PRFC_DETECT_QUIET;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign link_state = state_reg;

  // receive and transmit logic resets

  logic rx_done;
  logic tx_done;
  logic rx_reset_reg;
  logic tx_reset_reg;

  prfc_stable_cnt #(
    .W(prfc_pkg::CNT_W)
  ) u_rx_stable (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .level(sig_det_s),
    .limit(prfc_pkg::CNT_W'(RX_STABLE_CYC)),
    .done(rx_done)
  );

  prfc_stable_cnt #(
    .W(prfc_pkg::CNT_W)
  ) u_tx_stable (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .level(tx_pll_s),
    .limit(prfc_pkg::CNT_W'(prfc_pkg::TX_STABLE_CYC)),
    .done(tx_done)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_reset_reg <= 1'b1;
    end else if (ce) begin
      if (state_reg != prfc_pkg::PRFC_POLLING_ACTIVE) begin
        rx_reset_reg <= 1'b1;
      end else begin
        rx_reset_reg <= !rx_done;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_reset_reg <= 1'b1;
    end else if (ce) begin
      tx_reset_reg <= !(tx_done && serdes_por_n_reg);
    end
  end

  assign rx_digital_reset = rx_reset_reg;
  assign tx_digital_reset = tx_reset_reg;

  // register decode

  logic [prfc_pkg::VF_SEL_W-1:0] sel_field;
  logic [prfc_pkg::VF_IDX_W-1:0] sel;
  logic [7:0] ofs;
  logic vf_ok;
  logic cap_hit;
  logic dev_hit;
  logic pend_sel;

  assign sel_field = reg_addr[prfc_pkg::VF_SEL_LSB +: prfc_pkg::VF_SEL_W];
  assign sel = sel_field[prfc_pkg::VF_IDX_W-1:0];
  assign ofs = reg_addr[7:0];
  assign vf_ok = sel_field < prfc_pkg::VF_SEL_W'(prfc_pkg::NUM_VF);
  assign cap_hit = vf_ok && (ofs == prfc_pkg::CAP_LIST_OFS);
  assign dev_hit = vf_ok && (ofs == prfc_pkg::DEV_CTL_OFS);
  assign pend_sel = vf_np_pending[sel];

  // per-function reset handshake, version field and error flags

  logic [prfc_pkg::NUM_VF-1:0] flr_trig;
  logic [prfc_pkg::NUM_VF-1:0][prfc_pkg::ERR_W-1:0] err_q;
  logic [prfc_pkg::VER_W-1:0] ver_reg [prfc_pkg::NUM_VF];

  for (genvar i = 0; i < prfc_pkg::NUM_VF; i++) begin : g_vf
    logic hit_i;
    logic [prfc_pkg::ERR_W-1:0] clr_i;

    assign hit_i = reg_wr && (sel == prfc_pkg::VF_IDX_W'(i));
    assign flr_trig[i] = hit_i && dev_hit && reg_wdata[prfc_pkg::FLR_BIT]
                         && pf_flr_capable;
    assign clr_i = (hit_i && dev_hit) ? reg_wdata[prfc_pkg::ERR_LSB +: prfc_pkg::ERR_W]
                                      : '0;

    prfc_flr_fn u_fn (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .trigger(flr_trig[i]),
      .done_in(flr_done[i]),
      .err_set(vf_err_event[i]),
      .err_clr(clr_i),
      .active(flr_active[i]),
      .err_q(err_q[i])
    );

    always_ff @(posedge clock) begin
      if (rst) begin
        ver_reg[i] <= prfc_pkg::VER_RST;
      end else if (ce) begin
        if (flr_trig[i]) begin
          ver_reg[i] <= prfc_pkg::VER_RST;
        end else if (hit_i && cap_hit) begin
          ver_reg[i] <= reg_wdata[prfc_pkg::VER_LSB +: prfc_pkg::VER_W];
        end
      end
    end

    a_ver_reset: assert property (@(posedge clock) disable iff (rst)
      ce && flr_trig[i] |=> ver_reg[i] == prfc_pkg::VER_RST)
      else $error("version field not restored by function reset");
  end

  // read data

  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (cap_hit) begin
      rdata_next[prfc_pkg::CAP_ID_LSB +: 8] = prfc_pkg::CAP_ID_VAL;
      rdata_next[prfc_pkg::NEXT_PTR_LSB +: 8] = prfc_pkg::NEXT_PTR_VAL;
      rdata_next[prfc_pkg::VER_LSB +: prfc_pkg::VER_W] = ver_reg[sel];
    end else if (dev_hit) begin
      rdata_next[prfc_pkg::FLR_BIT] = 1'b0;
      rdata_next[prfc_pkg::ERR_LSB +: prfc_pkg::ERR_W] = err_q[sel];
      rdata_next[prfc_pkg::PEND_BIT] = pend_sel;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      rdata_reg <= reg_rd ? rdata_next : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;

  // checks

  a_core_release: assert property (@(posedge clock) disable iff (rst)
    ce && (perst_n || por_n) |=> !core_reset_status)
    else $error("core reset status not released");

  a_core_hold: assert property (@(posedge clock) disable iff (rst)
    ce && !perst_n && !por_n |=> core_reset_status)
    else $error("core reset status released while both resets held");

  a_serdes_por: assert property (@(posedge clock) disable iff (rst)
    ce && por_n |=> serdes_por_n)
    else $error("transceiver power-on reset not released");

  a_quiet_exit: assert property (@(posedge clock) disable iff (rst)
    link_state == prfc_pkg::PRFC_DETECT_ACTIVE
    && $past(link_state) == prfc_pkg::PRFC_DETECT_QUIET |-> $past(rx_pll_s))
    else $error("left detect-quiet without PLL lock");

  a_detect_done: assert property (@(posedge clock) disable iff (rst)
    link_state == prfc_pkg::PRFC_POLLING_ACTIVE
    && $past(link_state) == prfc_pkg::PRFC_DETECT_ACTIVE
    |-> $past(phy.phy_status) && $past(phy.rx_status) == prfc_pkg::RXSTAT_DETECTED)
    else $error("polling entered without receiver detect");

  a_enter_poll: assert property (@(posedge clock) disable iff (rst || core_rst_reg)
    ce && link_state == prfc_pkg::PRFC_DETECT_ACTIVE && rx_pll_s && rx_detected
    |=> link_state == prfc_pkg::PRFC_POLLING_ACTIVE)
    else $error("receiver detected but polling not entered");

  a_rx_reset_hold: assert property (@(posedge clock) disable iff (rst)
    $fell(rx_digital_reset) |-> $past(rx_done) && $past(sig_det_s))
    else $error("receive reset released before signal stable");

  a_rx_outside_poll: assert property (@(posedge clock) disable iff (rst)
    ce && link_state != prfc_pkg::PRFC_POLLING_ACTIVE |=> rx_digital_reset)
    else $error("receive reset not held outside polling");

  a_tx_reset_hold: assert property (@(posedge clock) disable iff (rst)
    $fell(tx_digital_reset) |-> $past(tx_done) && $past(tx_pll_s))
    else $error("transmit reset released before PLL stable");

  a_tx_por_gate: assert property (@(posedge clock) disable iff (rst)
    ce && !serdes_por_n |=> tx_digital_reset)
    else $error("transmit reset not held during transceiver power-on reset");

  a_flr_reads0: assert property (@(posedge clock) disable iff (rst)
    $past(ce && reg_rd && dev_hit) |-> !reg_rdata[prfc_pkg::FLR_BIT])
    else $error("function reset bit read back as one");

  a_flr_gate: assert property (@(posedge clock) disable iff (rst)
    ce && reg_wr && dev_hit && !pf_flr_capable |=> (flr_active & ~$past(flr_active)) == '0)
    else $error("function reset launched without capability");

  a_pending_bit: assert property (@(posedge clock) disable iff (rst)
    $past(ce && reg_rd && dev_hit) |-> reg_rdata[prfc_pkg::PEND_BIT] == $past(pend_sel))
    else $error("pending bit does not follow outstanding requests");

  a_cap_id: assert property (@(posedge clock) disable iff (rst)
    $past(ce && reg_rd && cap_hit)
    |-> reg_rdata[15:0] == {prfc_pkg::NEXT_PTR_VAL, prfc_pkg::CAP_ID_VAL})
    else $error("capability id or next pointer wrong");

endmodule

/* File: rtl/prfc_stable_cnt.sv */
`timescale 1ns/1ns
module prfc_stable_cnt #(
  parameter int W = 16
) (
  input logic clock,
  input logic rst,
  input logic ce,
  input logic level,
  input logic [W-1:0] limit,
  output logic done
);

  logic [W-1:0] cnt_reg;

  // counts cycles of an unbroken high level, saturating at limit
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (ce) begin
      if (!level) begin
        cnt_reg <= '0;
      end else if (cnt_reg != limit) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign done = level && (cnt_reg == limit);

  a_stable_restart: assert property (@(posedge clock) disable iff (rst)
    ce && !level |=> !done)
    else $error("stability count not restarted on dropout");

endmodule

/* File: testbench/prfc_app_model.sv */
`timescale 1ns/1ns
module prfc_app_model (
  input logic clock,
  input logic rst,
  input logic slow,
  input logic [prfc_pkg::NUM_VF-1:0] np_set,
  input logic [prfc_pkg::NUM_VF-1:0] flr_active,
  output logic [prfc_pkg::NUM_VF-1:0] flr_done,
  output logic [prfc_pkg::NUM_VF-1:0] vf_np_pending
);
  int wait_cnt [prfc_pkg::NUM_VF];
  // application side of the function reset handshake, prompt or slow
  always_ff @(posedge clock) begin
    for (int f = 0; f < prfc_pkg::NUM_VF; f++) begin
      if (rst) begin
        wait_cnt[f] <= 0;
        flr_done[f] <= 1'b0;
        vf_np_pending[f] <= 1'b0;
      end else if (flr_done[f]) begin
        flr_done[f] <= 1'b0;
      end else if (flr_active[f]) begin
        vf_np_pending[f] <= 1'b0;
        wait_cnt[f] <= wait_cnt[f] + 1;
        flr_done[f] <= (wait_cnt[f] >= (slow ? 9 : 0));
      end else begin
        wait_cnt[f] <= 0;
        vf_np_pending[f] <= vf_np_pending[f] | np_set[f];
      end
    end
  end
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic clock, rst, ce, perst_n, por_n, pf_flr_capable, reg_wr, reg_rd, slow;
  logic core_reset_status, serdes_por_n, rx_digital_reset, tx_digital_reset;
  prfc_pkg::prfc_phy_t phy;
  prfc_pkg::prfc_ltssm_t link_state;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] w;
  logic [3:0] flr_active, flr_done, vf_np_pending, np_set;
  logic [3:0][3:0] vf_err_event;
  int n_errors, checked;
  int ver [4];
  int err [4];
  int np [4];

  prfc_reset_flr_ctrl #(.RX_STABLE_CYC(20)) uut (
    .clock(clock), .rst(rst), .ce(ce), .perst_n(perst_n), .por_n(por_n),
    .phy(phy), .pf_flr_capable(pf_flr_capable), .core_reset_status(core_reset_status),
    .serdes_por_n(serdes_por_n), .rx_digital_reset(rx_digital_reset),
    .tx_digital_reset(tx_digital_reset), .link_state(link_state), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flr_active(flr_active), .flr_done(flr_done), .vf_np_pending(vf_np_pending),
    .vf_err_event(vf_err_event));

  prfc_app_model app (
    .clock(clock), .rst(rst), .slow(slow), .np_set(np_set), .flr_active(flr_active),
    .flr_done(flr_done), .vf_np_pending(vf_np_pending));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic finish_test;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for one output to reach a level
  task automatic wait_lvl(input int sel, input logic val, input int lim);
    int n;
    logic cur;
    n = 0;
    cur = ~val;
    while (n < lim && cur !== val) begin
      @(posedge clock);
      #1;
      case (sel)
        0: cur = tx_digital_reset;
        1: cur = rx_digital_reset;
        2: cur = link_state[1];
        3: cur = link_state[2];
        4: cur = |flr_active;
        5: cur = core_reset_status;
        default: cur = serdes_por_n;
      endcase
      n++;
    end
    chk_pin(cur, val);
    if (cur !== val) begin
      finish_test();
    end
  endtask

  // expected register contents from the bench model
  function automatic logic [31:0] ex(input logic [11:0] a);
    int f;
    f = a[11:8];
    ex = 32'h0000_0000;
    if (f < 4 && a[7:0] == 8'h80) begin
      ex = {13'h0000, ver[f][2:0], 16'h0010};
    end
    if (f < 4 && a[7:0] == 8'h88) begin
      ex = {10'h000, np[f][0], 1'b0, err[f][3:0], 16'h0000};
    end
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk_reg(reg_rdata, ex(a));
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    perst_n = 1'b0;
    por_n = 1'b0;
    phy = '0;
    pf_flr_capable = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slow = 1'b0;
    np_set = 4'h0;
    vf_err_event = '0;
    void'($urandom(32'hfeb56041));
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk_pin(core_reset_status, 1'b1);
    @(posedge clock);
    perst_n <= 1'b1;
    wait_lvl(5, 1'b0, 3);
    repeat (8) @(posedge clock);
    #1;
    chk_pin(serdes_por_n, 1'b0);
    chk_pin(link_state[0], 1'b1);
    @(posedge clock);
    por_n <= 1'b1;
    phy.tx_pll_locked <= 1'b1;
    wait_lvl(6, 1'b1, 3);
    repeat (118) @(posedge clock);
    #1;
    chk_pin(tx_digital_reset, 1'b1);
    wait_lvl(0, 1'b0, 20);
    @(posedge clock);
    phy.rx_pll_locked <= 1'b1;
    wait_lvl(2, 1'b1, 5);
    @(posedge clock);
    phy.phy_status <= 1'b1;
    phy.rx_status <= {1'b1, 2'($urandom())};
    @(posedge clock);
    phy.phy_status <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk_pin(link_state[1], 1'b1);
    @(posedge clock);
    phy.phy_status <= 1'b1;
    phy.rx_status <= 3'h3;
    @(posedge clock);
    phy.phy_status <= 1'b0;
    wait_lvl(3, 1'b1, 4);
    @(posedge clock);
    phy.signal_detect <= 1'b1;
    repeat (10) @(posedge clock);
    phy.signal_detect <= 1'b0;
    @(posedge clock);
    phy.signal_detect <= 1'b1;
    repeat (17) @(posedge clock);
    #1;
    chk_pin(rx_digital_reset, 1'b1);
    wait_lvl(1, 1'b0, 10);
    for (int f = 0; f < 4; f++) begin
      rd({f[3:0], 8'h80});
      w = $urandom();
      wr({f[3:0], 8'h80}, w);
      ver[f] = w[18:16];
      @(posedge clock);
      np_set[f] <= 1'($urandom());
      vf_err_event[f] <= 4'($urandom());
      @(posedge clock);
      np[f] = np_set[f];
      err[f] = vf_err_event[f];
      np_set <= 4'h0;
      vf_err_event <= '0;
      rd({f[3:0], 8'h88});
      w = $urandom() & 32'hffff_7fff;
      wr({f[3:0], 8'h88}, w);
      err[f] = err[f] & ~w[19:16];
      rd({f[3:0], 8'h88});
      if (f == 0) begin
        wr(12'h088, 32'h0000_8000);
        repeat (3) @(posedge clock);
        #1;
        chk_reg(32'(flr_active), 32'h0000_0000);
        rd(12'h080);
      end
      @(posedge clock);
      pf_flr_capable <= 1'b1;
      slow <= f[0];
      wr({f[3:0], 8'h88}, 32'h0000_8000);
      #1;
      chk_reg(32'(flr_active), 32'(1 << f));
      ver[f] = 0;
      err[f] = 0;
      np[f] = 0;
      rd({f[3:0], 8'h88});
      wait_lvl(4, 1'b0, 30);
      rd({f[3:0], 8'h80});
    end
    @(posedge clock);
    ce <= 1'b0;
    wr(12'h180, 32'h0005_0000);
    ce <= 1'b1;
    rd(12'h180);
    wr(12'h280, 32'h0007_0000);
    ver[2] = 7;
    wr(12'h188, 32'h0000_8000);
    rd(12'h280);
    wait_lvl(4, 1'b0, 30);
    wr(12'h480, 32'hffff_ffff);
    rd(12'h480);
    rd(12'h084);
    rd(12'h080);
    finish_test();
  end
endmodule
